// ---- hw/sadc_device.sv ----
// Device end: conversion control, result latches and output enable
`timescale 1ns/1ps

module sadc_device
    import sadc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    sadc_if.device                   link,
    input  wire logic [RESULT_W-1:0] sample_value,   // Two's complement analog sample
    output logic      [1:0]          power_state,    // Current power state
    output logic                     conv_done       // One-cycle pulse at conversion end
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] cs_sync;        // Chip select sync stages
    logic [1:0] cv_sync;        // Convert start sync stages
    logic [1:0] rd_sync;        // Read sync stages
    logic [1:0] pd_sync;        // Power-down sync stages
    logic       cv_last;        // Convert start, previous synced value

    // Two stages before any logic; only stage 2 is read downstream
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cs_sync <= 2'b11;
            cv_sync <= 2'b11;
            rd_sync <= 2'b11;
            pd_sync <= 2'b11;
            cv_last <= 1'b1;
        end else begin
            cs_sync <= {cs_sync[0], link.chip_sel_n};
            cv_sync <= {cv_sync[0], link.conv_start_n};
            rd_sync <= {rd_sync[0], link.read_n};
            pd_sync <= {pd_sync[0], link.power_down_n};
            cv_last <= cv_sync[1];
        end
    end

    logic cs_n;                 // Synced select
    logic rd_n;                 // Synced read
    logic pd_n;                 // Synced power-down
    logic start_edge;           // Qualified start request

    assign cs_n = cs_sync[1];
    assign rd_n = rd_sync[1];
    assign pd_n = pd_sync[1];
    // Falling edge counts only with select low and power up
    assign start_edge = cv_last && !cv_sync[1] && !cs_n && pd_n;

    // ----------------------------------------------------------------
    // Power state
    // ----------------------------------------------------------------
    // Nap and sleep only block new starts; the latches and sequencer
    // keep their state, so a result survives a power-down
    sadc_pwr_t pwr;             // Current power mode

    // Select picks the flavour of power-down while the pin is low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pwr <= SADC_PWR_ACTIVE;
        end else if (!pd_n) begin
            pwr <= cs_n ? SADC_PWR_SLEEP : SADC_PWR_NAP;
        end else begin
            pwr <= SADC_PWR_ACTIVE;
        end
    end

    assign power_state = pwr;

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        SADC_ST_IDLE,
        SADC_ST_CONV
    } sadc_state_t;

    sadc_state_t         state;        // Sequencer state
    logic [CNT_W-1:0]    step_cnt;     // Cycles within current bit
    logic [4:0]          bit_idx;      // Bit being decided
    logic [RESULT_W-1:0] approx_register;  // Successive approximation word
    logic [RESULT_W-1:0] held_sample;  // Sample frozen at start
    logic [RESULT_W-1:0] result;       // Output latches
    logic                finish;       // Last step of last bit

    assign finish = (state == SADC_ST_CONV) && (bit_idx == 5'd0)
                    && (step_cnt == CNT_W'(BIT_CYC - 1));

    // Sequencer: idle waits for a start, conversion ignores further edges
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state    <= SADC_ST_IDLE;
            step_cnt <= '0;
            bit_idx  <= 5'd0;
        end else begin
            unique case (state)
                SADC_ST_IDLE: begin
                    if (start_edge) begin
                        state    <= SADC_ST_CONV;
                        step_cnt <= '0;
                        bit_idx  <= 5'(RESULT_W - 1);
                    end
                end
                SADC_ST_CONV: begin
                    // Start edges here fall through unseen
                    if (step_cnt == CNT_W'(BIT_CYC - 1)) begin
                        step_cnt <= '0;
                        if (bit_idx == 5'd0) begin
                            state <= SADC_ST_IDLE;
                        end else begin
                            bit_idx <= bit_idx - 5'd1;
                        end
                    end else begin
                        step_cnt <= step_cnt + CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // Trial bit compare: signed sample offset to unsigned weight space
    function automatic logic [RESULT_W-1:0] sadc_offset(input logic [RESULT_W-1:0] v);
        sadc_offset = {~v[RESULT_W-1], v[RESULT_W-2:0]};
    endfunction : sadc_offset

    logic [RESULT_W-1:0] trial;        // Current guess with bit set
    assign trial = approx_register | (RESULT_W'(1) << bit_idx);

    // Register clears at start, bits decided MSB first on each bit's end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            approx_register <= '0;
            held_sample     <= '0;
        end else if (state == SADC_ST_IDLE && start_edge) begin
            approx_register <= '0;
            held_sample     <= sadc_offset(sample_value);
        end else if (state == SADC_ST_CONV && step_cnt == CNT_W'(BIT_CYC - 1)) begin
            if (trial <= held_sample) begin
                approx_register <= trial;
            end
        end
    end

    // Output latches load once per conversion and hold otherwise
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            result <= RESULT_RST;
        end else if (finish) begin
            // Final word back to two's complement, MSB on top line
            if (trial <= held_sample) begin
                result <= sadc_offset(trial);
            end else begin
                result <= sadc_offset(approx_register);
            end
        end
    end

    // Busy rises on the edge that loads the latches, so the word is
    // ready when the rise is seen. A start on the finishing cycle is
    // dropped, else busy would stay low with nothing running.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            link.busy_n <= 1'b1;
            conv_done   <= 1'b0;
        end else begin
            link.busy_n <= !(state == SADC_ST_CONV && !finish)
                           && !(state == SADC_ST_IDLE && start_edge);
            conv_done   <= finish;
        end
    end

    // ----------------------------------------------------------------
    // Result bus drive
    // ----------------------------------------------------------------
    // Drive straight from the latches: slow mode shows old word until
    // completion, ROM mode reads the previous word during the start pulse
    assign link.result_out = result;
    // Enable uses synced pins, so it lags the pins by two clocks
    assign link.result_oe  = !rd_n && !cs_n;

endmodule : sadc_device

// ---- hw/sadc_host.sv ----
// Host end: drives select, start, read and power-down; captures results
`timescale 1ns/1ps

module sadc_host
    import sadc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    sadc_if.host                     link,
    input  wire sadc_mode_t          mode,          // Interface mode
    input  wire logic                convert_req,   // Pulse: request a conversion
    input  wire logic                nap_req,       // Level: hold nap
    input  wire logic                sleep_req,     // Level: hold sleep
    output logic                     host_ready,    // Can take a request
    output logic [RESULT_W-1:0]      captured,      // Last captured result
    output logic                     captured_valid // One-cycle pulse
);

    // ----------------------------------------------------------------
    // Synchronise device outputs
    // ----------------------------------------------------------------
    logic [1:0]          busy_sync;    // Busy sync stages
    logic                busy_last;    // Previous synced busy
    logic [RESULT_W-1:0] bus_s1;       // Bus sync stage 1
    logic [RESULT_W-1:0] bus_s2;       // Bus sync stage 2

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy_sync <= 2'b11;
            busy_last <= 1'b1;
            bus_s1    <= '0;
            bus_s2    <= '0;
        end else begin
            busy_sync <= {busy_sync[0], link.busy_n};
            busy_last <= busy_sync[1];
            bus_s1    <= link.result_bus;
            bus_s2    <= bus_s1;
        end
    end

    logic busy_rise;                   // Conversion end seen
    assign busy_rise = !busy_last && busy_sync[1];

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SADC_H_WAKE,      // Wake or acquisition wait
        SADC_H_IDLE,      // Ready for a request
        SADC_H_START,     // Start strobe low
        SADC_H_WAIT,      // Waiting for busy to rise
        SADC_H_READ,      // Read strobe low
        SADC_H_DOWN       // Powered down
    } sadc_hstate_t;

    sadc_hstate_t     st;          // Host state
    logic [CNT_W-1:0] cnt;         // Timing counter
    logic             cs_n;        // Select drive
    logic             cv_n;        // Start drive
    logic             rd_n;        // Read drive
    logic             pd_n;        // Power-down drive
    logic             combined;    // Strobe modes tie start and read

    assign combined = (mode == SADC_MODE_SLOW) || (mode == SADC_MODE_ROM);

    // Walks one conversion; waits cover acquisition and nap wake-up.
    // Sleep wake-up settling is left to the caller, which holds off requests.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st   <= SADC_H_WAKE;
            cnt  <= CNT_W'(ACQ_CYC);
            cs_n <= 1'b1;
            cv_n <= 1'b1;
            rd_n <= 1'b1;
            pd_n <= 1'b1;
            captured       <= '0;
            captured_valid <= 1'b0;
        end else begin
            captured_valid <= 1'b0;
            unique case (st)
                SADC_H_WAKE: begin
                    cs_n <= 1'b0;
                    rd_n <= (mode == SADC_MODE_TIED) ? 1'b0 : 1'b1;
                    if (cnt == '0) st <= SADC_H_IDLE;
                    else cnt <= cnt - CNT_W'(1);
                end
                SADC_H_IDLE: begin
                    if (nap_req || sleep_req) begin
                        pd_n <= 1'b0;
                        cs_n <= sleep_req;      // Select high picks sleep
                        st   <= SADC_H_DOWN;
                    end else if (convert_req) begin
                        cv_n <= 1'b0;
                        if (combined) rd_n <= 1'b0;
                        cnt  <= CNT_W'(CPULSE_CYC);
                        st   <= SADC_H_START;
                    end
                end
                SADC_H_START: begin
                    // Short pulse raised early, except slow mode holds it
                    if (cnt == '0) begin
                        if (mode != SADC_MODE_SLOW) begin
                            cv_n <= 1'b1;
                            if (mode == SADC_MODE_ROM) rd_n <= 1'b1;
                        end
                        // ROM pulse hands back the previous word
                        if (mode == SADC_MODE_ROM) begin
                            captured       <= bus_s2;
                            captured_valid <= 1'b1;
                        end
                        st <= SADC_H_WAIT;
                    end else cnt <= cnt - CNT_W'(1);
                end
                SADC_H_WAIT: begin
                    if (busy_rise) begin
                        cv_n <= 1'b1;
                        if (mode == SADC_MODE_TIED) begin
                            captured       <= bus_s2;
                            captured_valid <= 1'b1;
                            cnt <= CNT_W'(ACQ_CYC);
                            st  <= SADC_H_WAKE;
                        end else if (mode == SADC_MODE_SLOW) begin
                            cnt <= CNT_W'(RPULSE_CYC);
                            st  <= SADC_H_READ;    // Strobe still low, settle read
                        end else if (mode == SADC_MODE_ROM) begin
                            cnt <= CNT_W'(ACQ_CYC);
                            st  <= SADC_H_WAKE;
                        end else begin
                            rd_n <= 1'b0;
                            cnt  <= CNT_W'(RPULSE_CYC);
                            st   <= SADC_H_READ;
                        end
                    end
                end
                SADC_H_READ: begin
                    if (cnt == '0) begin
                        captured       <= bus_s2;
                        captured_valid <= 1'b1;
                        rd_n <= 1'b1;
                        cnt  <= CNT_W'(ACQ_CYC);
                        st   <= SADC_H_WAKE;
                    end else cnt <= cnt - CNT_W'(1);
                end
                SADC_H_DOWN: begin
                    if (!nap_req && !sleep_req) begin
                        pd_n <= 1'b1;
                        cs_n <= 1'b0;
                        cnt  <= CNT_W'(NAP_CYC);
                        st   <= SADC_H_WAKE;
                    end else begin
                        cs_n <= sleep_req;      // Follow nap or sleep
                    end
                end
                default: st <= SADC_H_WAKE;
            endcase
        end
    end

    assign link.chip_sel_n   = cs_n;
    assign link.conv_start_n = cv_n;
    assign link.read_n       = rd_n;
    assign link.power_down_n = pd_n;
    assign host_ready        = (st == SADC_H_IDLE);

endmodule : sadc_host

// ---- hw/sadc_if.sv ----
// Interface joining the converter device end and its host end
`timescale 1ns/1ps

interface sadc_if;
    import sadc_pkg::*;

    logic                chip_sel_n;     // Active-low chip select
    logic                conv_start_n;   // Active-low convert start
    logic                read_n;         // Active-low read
    logic                power_down_n;   // Active-low power-down
    logic                busy_n;         // Low while converting
    logic [RESULT_W-1:0] result_out;     // Device result drive value
    logic                result_oe;      // Device drives result bus
    logic [RESULT_W-1:0] result_bus;     // Resolved bus level

    // Undriven bus reads as zero here; the bench may model float otherwise
    assign result_bus = result_oe ? result_out : '0;

    modport device (
        input  chip_sel_n,
        input  conv_start_n,
        input  read_n,
        input  power_down_n,
        output busy_n,
        output result_out,
        output result_oe
    );

    modport host (
        output chip_sel_n,
        output conv_start_n,
        output read_n,
        output power_down_n,
        input  busy_n,
        input  result_bus
    );

endinterface : sadc_if

// ---- hw/sadc_pkg.sv ----
// Package of shared constants and types for the converter control block
package sadc_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int RESULT_W = 16;                 // Result word width

    // ----------------------------------------------------------------
    // Timing in nanoseconds and derived cycle counts at 100 MHz
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;           // Clock period
    localparam int CONV_TYP_NS    = 2450;         // Typical conversion time
    localparam int CONV_MAX_NS    = 2800;         // Longest conversion time
    localparam int ACQ_MIN_NS     = 480;          // Least acquisition time
    localparam int NAP_WAKE_NS    = 200;          // Nap wake-up time
    localparam int CONV_PULSE_NS  = 40;           // Host start strobe low time
    localparam int READ_PULSE_NS  = 60;           // Host read strobe low time

    // Typical time rounds down so the busy window never passes the maximum
    localparam int CONV_CYC   = CONV_TYP_NS / CLK_PERIOD_NS;
    localparam int CONVMAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    // Cycles per bit decision; 16 steps must fit inside the conversion
    localparam int BIT_CYC    = CONV_CYC / RESULT_W;
    // Least times round up
    localparam int ACQ_CYC    = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NAP_CYC    = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CPULSE_CYC = (CONV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RPULSE_CYC = (READ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 12;                    // Width of timing counters

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RESULT_RST = 16'h0000;  // Output latches at reset

    // ----------------------------------------------------------------
    // Host interface modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SADC_MODE_TIED,     // Select and read held low, bus driven, except in sleep where select is high
        SADC_MODE_SHARED,   // Select low, read pulsed per result
        SADC_MODE_SLOW,     // Combined strobe held low until busy rises
        SADC_MODE_ROM       // Combined strobe pulse starts and reads
    } sadc_mode_t;

    // Power state seen by the device
    typedef enum logic [1:0] {
        SADC_PWR_ACTIVE,
        SADC_PWR_NAP,
        SADC_PWR_SLEEP
    } sadc_pwr_t;

endpackage : sadc_pkg

// ---- tb/sadc_assertions.sv ----
// Concurrent checks on the link between the host end and the device end
`timescale 1ns/1ps

module sadc_checker
    import sadc_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst_b,
    input wire logic                chip_sel_n,
    input wire logic                conv_start_n,
    input wire logic                read_n,
    input wire logic                power_down_n,
    input wire logic                busy_n,
    input wire logic [RESULT_W-1:0] result_out,
    input wire logic                result_oe
);
    // ----------------------------------------------------------------
    // Busy length counter
    // ----------------------------------------------------------------
    localparam int BUSY_CYC = RESULT_W * BIT_CYC;   // Cycles busy stays low
    logic [CNT_W-1:0] low_cnt;                        // Busy low cycles so far

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Counts while converting, so a restart shows up as a long busy
    always_ff @(posedge clk) begin
        if (!rst_b || busy_n) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= low_cnt + CNT_W'(1);
        end
    end

    a_oe_needs_sel: assert property (result_oe |-> $past(!read_n && !chip_sel_n, 2))
        else $error("bus driven without read and select");
    a_oe_tied_on: assert property ((!read_n && !chip_sel_n)[*3] |-> result_oe)
        else $error("bus not driven with read and select low");
    a_oe_stays_off: assert property ((read_n || chip_sel_n)[*3] |-> !result_oe)
        else $error("bus driven while not read");
    a_start_taken: assert property (($fell(conv_start_n) && busy_n && $past(busy_n, 4)
        && power_down_n && $past(power_down_n, 4) ##0 (!chip_sel_n)[*3]) |-> ##[1:4] !busy_n)
        else $error("selected start edge ignored");
    a_start_cause: assert property ($fell(busy_n) |->
        $past(!conv_start_n && !chip_sel_n && power_down_n, 3))
        else $error("conversion began without a selected start");
    a_busy_span: assert property ($rose(busy_n) |-> low_cnt == CNT_W'(BUSY_CYC))
        else $error("busy low time differs from conversion length");
    a_busy_held: assert property (!busy_n && low_cnt < CNT_W'(BUSY_CYC - 1) |=> !busy_n)
        else $error("busy ended early");
    a_busy_max: assert property (!busy_n |-> low_cnt < CNT_W'(CONVMAX_CYC))
        else $error("conversion longer than allowed");
    a_result_hold: assert property ($changed(result_out) |-> $rose(busy_n))
        else $error("latch changed away from conversion end");
    a_nap_idle: assert property ((busy_n && !power_down_n)[*4] |=> busy_n)
        else $error("conversion began in power-down");
endmodule : sadc_checker

// ---- tb/testbench.sv ----
// Testbench joining host and device ends, plus a bare device driven directly
`timescale 1ns/1ps

module testbench
    import sadc_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic                clk = 1'b0;     // 100 MHz clock
    logic                rst_b;          // Synchronous reset, active low
    sadc_mode_t          mode;           // Host interface mode
    logic                convert_req;    // Host request pulse
    logic                nap_req;        // Host nap level
    logic                sleep_req;      // Host sleep level
    logic [RESULT_W-1:0] sample_value;   // Analog level for the joined device
    logic [RESULT_W-1:0] sample_b;       // Analog level for the bare device
    logic                host_ready;     // Host takes requests
    logic [RESULT_W-1:0] captured;       // Host result
    logic                captured_valid; // Host result strobe
    logic [1:0]          power_state;    // Joined device power state
    logic                conv_done_b;    // Bare device done pulse
    int                  err_count;      // Mismatches
    int                  tests_run;      // Comparisons
    int                  cycles = 0;     // Watchdog count

    sadc_if link ();
    sadc_if link_b ();

    sadc_device sadc_device_i (.clk(clk), .rst_b(rst_b), .link(link),
        .sample_value(sample_value), .power_state(power_state), .conv_done());
    // Second device faces the bench so the host side rules can be broken
    sadc_device sadc_device_i2 (.clk(clk), .rst_b(rst_b), .link(link_b),
        .sample_value(sample_b), .power_state(), .conv_done(conv_done_b));
    sadc_host sadc_host_i (.clk(clk), .rst_b(rst_b), .link(link), .mode(mode),
        .convert_req(convert_req), .nap_req(nap_req), .sleep_req(sleep_req),
        .host_ready(host_ready), .captured(captured), .captured_valid(captured_valid));
    sadc_checker sadc_checker_i (.clk(clk), .rst_b(rst_b), .chip_sel_n(link.chip_sel_n),
        .conv_start_n(link.conv_start_n), .read_n(link.read_n),
        .power_down_n(link.power_down_n), .busy_n(link.busy_n),
        .result_out(link.result_out), .result_oe(link.result_oe));

    always #5 clk = ~clk;

    // Watchdog: a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles > 40000) begin
            err_count++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp,
                         input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Bounded waits so a stuck handshake ends the run cleanly
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (link.busy_n !== lvl && n < 3000) begin tick(1); n++; end
        check(16'(n < 3000), 16'h0001, "busy wait");
    endtask : wait_busy

    task automatic host_conv(input logic [RESULT_W-1:0] val);
        int n;
        n = 0;
        sample_value = val;
        while (host_ready !== 1'b1 && n < 3000) begin tick(1); n++; end
        convert_req = 1'b1;
        tick(1);
        convert_req = 1'b0;
    endtask : host_conv

    task automatic host_cap(input logic [RESULT_W-1:0] exp);
        int n;
        n = 0;
        while (captured_valid !== 1'b1 && n < 3000) begin tick(1); n++; end
        check(captured, exp, "captured");
    endtask : host_cap

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_tied();
        mode = SADC_MODE_TIED;
        host_conv(16'h8000);
        host_cap(16'h8000);
        check(link.result_bus, 16'h8000, "tied bus");
        host_conv(16'h7fff);
        host_cap(16'h7fff);
    endtask : t_tied

    task automatic t_shared();
        mode = SADC_MODE_SHARED;
        host_conv(16'h0001);
        wait_busy(1'b0);
        tick(50);
        check(16'(link.result_oe), 16'h0000, "shared float");
        host_cap(16'h0001);
    endtask : t_shared

    task automatic t_slow();
        mode = SADC_MODE_SLOW;
        host_conv(16'h1234);
        wait_busy(1'b0);
        tick(100);
        check(link.result_bus, 16'h0001, "old result");
        host_cap(16'h1234);
    endtask : t_slow

    task automatic t_rom();
        mode = SADC_MODE_ROM;
        host_conv(16'hfffe);
        host_cap(16'h1234);
        wait_busy(1'b0);
        wait_busy(1'b1);
        check(link.result_out, 16'hfffe, "latched");
        host_conv(16'h0000);
        host_cap(16'hfffe);
    endtask : t_rom

    task automatic t_power();
        mode = SADC_MODE_TIED;
        tick(3000);
        nap_req = 1'b1;
        tick(10);
        check(16'(power_state), 16'(SADC_PWR_NAP), "nap");
        nap_req = 1'b0;
        sleep_req = 1'b1;
        tick(10);
        check(16'(power_state), 16'(SADC_PWR_SLEEP), "sleep");
        sleep_req = 1'b0;
        tick(100);
        host_conv(16'h4321);
        host_cap(16'h4321);
    endtask : t_power

    // Bare device: deselected and powered-down starts, then a restart attempt
    task automatic t_direct();
        int n;
        sample_b = 16'h5a5a;
        link_b.conv_start_n = 1'b0;
        link_b.read_n = 1'b0;
        tick(4);
        link_b.conv_start_n = 1'b1;
        tick(10);
        check(16'({link_b.busy_n, link_b.result_oe}), 16'h0002, "deselected");
        link_b.read_n = 1'b1;
        link_b.chip_sel_n = 1'b0;
        link_b.power_down_n = 1'b0;
        tick(10);
        link_b.conv_start_n = 1'b0;
        tick(4);
        link_b.conv_start_n = 1'b1;
        tick(10);
        check(16'(link_b.busy_n), 16'h0001, "nap start");
        link_b.power_down_n = 1'b1;
        tick(NAP_CYC + 10);
        link_b.conv_start_n = 1'b0;
        n = 0;
        while (link_b.busy_n !== 1'b0 && n < 8) begin tick(1); n++; end
        check(16'(n < 8), 16'h0001, "start");
        n = 0;
        while (link_b.busy_n === 1'b0 && n < 3000) begin
            if (n == 2 || n == 104) link_b.conv_start_n = 1'b1;
            if (n == 100) link_b.conv_start_n = 1'b0;
            tick(1);
            n++;
        end
        check(16'(n), 16'(RESULT_W * BIT_CYC), "busy length");
        check(link_b.result_out, 16'h5a5a, "bare result");
        check(16'(conv_done_b), 16'h0001, "done pulse");
    endtask : t_direct

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial begin
        rst_b = 1'b0;
        mode = SADC_MODE_TIED;
        convert_req = 1'b0;
        nap_req = 1'b0;
        sleep_req = 1'b0;
        sample_value = 16'h0000;
        sample_b = 16'h0000;
        err_count = 0;
        tests_run = 0;
        link_b.chip_sel_n = 1'b1;
        link_b.conv_start_n = 1'b1;
        link_b.read_n = 1'b1;
        link_b.power_down_n = 1'b1;
        tick(10);
        rst_b = 1'b1;
        t_tied();
        t_shared();
        t_slow();
        t_rom();
        t_power();
        t_direct();
        test_done();
    end
endmodule : testbench
